//--- design/gpp_port.sv
// Added by the designer: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
// Contract
// - Up to twelve pins, top pin optional
// - Unassigned pin has its driver off
// - Configuration reapplied on device or application reset
// - Two pin interrupts, five trigger kinds
// - Interrupt detection independent of pin function
// - Timer interrupt condition follows timer mode
// - Special function excludes plain use of pin
// - Nibble read of four pins, bits still readable
// - Latest plain direction config sets run direction
// - Plain config never changes special function direction
// - Special function direction wins, any order
// - Plain direction changeable by software at run time
// - Output pin reads back actual pin level
// - Plain output starts at configured value, default 0
// - Plain inputs synchronised to system clock
module gpp_port
   import gpp_pkg::*;
#(
   parameter int NUM_PINS = PIN_CNT,
   parameter bit HAS_TOP_PIN = 1'b1
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [REG_AW-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [REG_AW-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire logic [NUM_PINS-1:0] pin_i,
   output logic [NUM_PINS-1:0] pin_o,
   output logic [NUM_PINS-1:0] pin_oe,
   input wire logic [NUM_PINS-1:0] spec_o,
   output logic [NUM_PINS-1:0] spec_i,
   input wire logic tc_done_i,
   output logic [1:0] pin_irq,
   output logic irq
);
   // Pins that exist on this variant
   logic [NUM_PINS-1:0] exist;
   // Configuration registers
   logic [NUM_PINS-1:0] plain_en_ff; // Pins used by plain modes
   logic [NUM_PINS-1:0] plain_dir_ff; // Configured plain direction, 1 drives
   logic [NUM_PINS-1:0] out_init_ff; // Value driven after a reset
   logic [NUM_PINS-1:0] hard_sel_ff; // Pins owned by a fixed-direction function
   logic [NUM_PINS-1:0] hard_dir_ff; // Direction of those functions
   // Run-time state
   logic [NUM_PINS-1:0] out_ff; // Plain output value
   logic [NUM_PINS-1:0] dir_rt_ff; // Run-time plain direction
   logic [3:0] nib_base_ff; // Lowest pin of the nibble read
   logic [7:0] pirq_ff [2]; // Pin interrupt configs
   logic [5:0] tc_cfg_ff; // Timer/counter interrupt config
   logic [STAT_W-1:0] stat_ff; // Sticky events
   logic [STAT_W-1:0] mask_ff; // Interrupt enables
   // Bus state
   logic aw_got_ff;
   logic w_got_ff;
   logic [REG_AW-1:0] waddr_ff;
   logic [31:0] wd_ff;
   logic [3:0] ws_ff;
   logic bvalid_ff;
   logic [1:0] bresp_ff;
   logic rvalid_ff;
   logic [31:0] rdata_ff;
   logic [1:0] rresp_ff;
   // Decoded strobes
   logic wr_fire;
   logic [31:0] wm;
   logic app_rst;
   logic wr_hit;
   logic [NUM_PINS-1:0] in_sync;
   logic [NUM_PINS-1:0] plain_own;
   logic [2:0] hit;
   logic [3:0] src_idx [3];
   logic [2:0] trig_code [3];
   logic [2:0] lvl_sel;
   logic [1:0] tc_mode;
   logic tc_hit;
   logic [STAT_W-1:0] ev;
   logic [STAT_W-1:0] clr;
   logic [31:0] nxt_rdata;
   logic nxt_rerr;
   logic [3:0] nib;

   assign exist = HAS_TOP_PIN ? {NUM_PINS{1'b1}} : {1'b0, {(NUM_PINS-1){1'b1}}};

   // Plain pins are sampled through the synchroniser only
   gpp_sync #(.W(NUM_PINS)) u_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      .raw(pin_i),
      .clean(in_sync)
   );

   assign spec_i = in_sync;

   // Write channel acceptance: address and data in either order
   assign awready = !aw_got_ff;
   assign wready = !w_got_ff;
   assign wr_fire = aw_got_ff && w_got_ff && !bvalid_ff;
   assign wm = {{8{ws_ff[3]}}, {8{ws_ff[2]}}, {8{ws_ff[1]}}, {8{ws_ff[0]}}};

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_got_ff <= 1'b0;
         waddr_ff <= '0;
      end else if (awvalid && awready) begin
         aw_got_ff <= 1'b1;
         waddr_ff <= awaddr;
      end else if (wr_fire) begin
         aw_got_ff <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_got_ff <= 1'b0;
         wd_ff <= '0;
         ws_ff <= '0;
      end else if (wvalid && wready) begin
         w_got_ff <= 1'b1;
         wd_ff <= wdata;
         ws_ff <= wstrb;
      end else if (wr_fire) begin
         w_got_ff <= 1'b0;
      end
   end

   // Known offsets answer OKAY; anything else is refused with SLVERR
   always_comb begin
      case ({waddr_ff[REG_AW-1:2], 2'b00})
         OFF_PLAIN_EN, OFF_PLAIN_DIR, OFF_OUT_INIT, OFF_OUT_DATA, OFF_HARD_SEL,
         OFF_HARD_DIR, OFF_PIN_IN, OFF_NIB_IN, OFF_CTRL, OFF_RT_DIR, OFF_PIRQ0,
         OFF_PIRQ1, OFF_TC_CFG, OFF_IRQ_STAT, OFF_IRQ_MASK: wr_hit = 1'b1;
         default: wr_hit = 1'b0;
      endcase
   end

   // Write response held until taken
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_ff <= 1'b0;
         bresp_ff <= RESP_OKAY;
      end else if (wr_fire) begin
         bvalid_ff <= 1'b1;
         bresp_ff <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (bready) begin
         bvalid_ff <= 1'b0;
      end
   end

   assign bvalid = bvalid_ff;
   assign bresp = bresp_ff;

   function automatic logic [NUM_PINS-1:0] merge(input logic [NUM_PINS-1:0] old);
      merge = (old & ~wm[NUM_PINS-1:0]) | (wd_ff[NUM_PINS-1:0] & wm[NUM_PINS-1:0]);
   endfunction

   function automatic logic wr_to(input logic [7:0] off);
      wr_to = wr_fire && ({waddr_ff[REG_AW-1:2], 2'b00} == off);
   endfunction

   // Application reset is a self-clearing control bit
   assign app_rst = wr_to(OFF_CTRL) && ws_ff[0] && wd_ff[CTRL_APP_RST_BIT];

   // Configuration registers survive an application reset
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         plain_en_ff <= '0;
         plain_dir_ff <= '0;
         out_init_ff <= '0;
         hard_sel_ff <= '0;
         hard_dir_ff <= '0;
      end else begin
         if (wr_to(OFF_PLAIN_EN)) plain_en_ff <= merge(plain_en_ff) & exist;
         if (wr_to(OFF_PLAIN_DIR)) plain_dir_ff <= merge(plain_dir_ff);
         if (wr_to(OFF_OUT_INIT)) out_init_ff <= merge(out_init_ff);
         if (wr_to(OFF_HARD_SEL)) hard_sel_ff <= merge(hard_sel_ff) & exist;
         if (wr_to(OFF_HARD_DIR)) hard_dir_ff <= merge(hard_dir_ff);
      end
   end

   // Run-time direction: latest plain config or software change wins
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         dir_rt_ff <= '0;
      end else if (app_rst) begin
         dir_rt_ff <= plain_dir_ff;
      end else if (wr_to(OFF_PLAIN_DIR)) begin
         dir_rt_ff <= merge(plain_dir_ff);
      end else if (wr_to(OFF_RT_DIR)) begin
         dir_rt_ff <= merge(dir_rt_ff);
      end
   end

   // Plain output value, reloaded from its initial value on reset
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         out_ff <= '0;
      end else if (app_rst) begin
         out_ff <= out_init_ff;
      end else if (wr_to(OFF_OUT_DATA)) begin
         out_ff <= merge(out_ff);
      end
   end

   // Interrupt and nibble configuration
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pirq_ff[0] <= RST_PIRQ;
         pirq_ff[1] <= RST_PIRQ;
         tc_cfg_ff <= RST_TC;
         nib_base_ff <= RST_NIB;
         mask_ff <= '0;
      end else begin
         if (wr_to(OFF_PIRQ0) && ws_ff[0]) pirq_ff[0] <= wd_ff[7:0];
         if (wr_to(OFF_PIRQ1) && ws_ff[0]) pirq_ff[1] <= wd_ff[7:0];
         if (wr_to(OFF_TC_CFG) && ws_ff[0]) tc_cfg_ff <= wd_ff[5:0];
         if (wr_to(OFF_CTRL) && ws_ff[0]) nib_base_ff <= wd_ff[CTRL_NIB_LSB +: 4];
         if (wr_to(OFF_IRQ_MASK) && ws_ff[0]) mask_ff <= wd_ff[STAT_W-1:0];
      end
   end

   // A special function takes the pin; plain modes only share with each other
   assign plain_own = plain_en_ff & ~hard_sel_ff & exist;

   // Driver: special function direction first, then plain, else high impedance
   assign pin_oe = (hard_sel_ff & hard_dir_ff & exist) | (plain_own & dir_rt_ff);
   assign pin_o = (hard_sel_ff & spec_o) | (plain_own & out_ff);

   // Detector sources: two pin interrupts and the timer/counter pin
   assign tc_mode = tc_cfg_ff[TC_MODE_LSB +: 2];
   always_comb begin
      src_idx[0] = pirq_ff[0][PIRQ_PIN_LSB +: 4];
      src_idx[1] = pirq_ff[1][PIRQ_PIN_LSB +: 4];
      src_idx[2] = tc_cfg_ff[TC_PIN_LSB +: 4];
      trig_code[0] = pirq_ff[0][PIRQ_TRIG_LSB +: 3];
      trig_code[1] = pirq_ff[1][PIRQ_TRIG_LSB +: 3];
      trig_code[2] = (tc_mode == TC_CAP_FALL) ? TRIG_FALL : TRIG_RISE;
   end

   // Detectors watch the synchronised level whatever drives the pin
   for (genvar k = 0; k < 3; k++) begin : g_det
      assign lvl_sel[k] = (32'(src_idx[k]) < NUM_PINS) ? in_sync[src_idx[k]] : 1'b0;
      gpp_trig u_trig (
         .aclk(aclk),
         .aresetn(aresetn),
         .lvl(lvl_sel[k]),
         .trig(trig_code[k]),
         .hit(hit[k])
      );
   end

   // Raw pin interrupt levels; level triggers stay high with the level
   assign pin_irq[0] = hit[0] && pirq_ff[0][PIRQ_EN_BIT];
   assign pin_irq[1] = hit[1] && pirq_ff[1][PIRQ_EN_BIT];

   // Timer/counter event: pin capture edge or the counter's own done pulse
   always_comb begin
      case (tc_mode)
         TC_CAP_RISE, TC_CAP_FALL: tc_hit = hit[2];
         TC_DONE: tc_hit = tc_done_i;
         default: tc_hit = 1'b0;
      endcase
   end

   // Sticky status; a new event beats a clear in the same cycle
   assign ev = {tc_hit, pin_irq[1], pin_irq[0]};
   assign clr = (wr_to(OFF_IRQ_STAT) && ws_ff[0]) ? wd_ff[STAT_W-1:0] : '0;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         stat_ff <= '0;
      end else begin
         stat_ff <= (stat_ff & ~clr) | ev;
      end
   end

   assign irq = |(stat_ff & mask_ff);

   // Nibble of four adjacent synchronised pins; bits at or past NUM_PINS read zero, an absent top pin reads its input
   always_comb begin
      nib = '0;
      for (int b = 0; b < 4; b++) begin
         if (32'(nib_base_ff) + b < NUM_PINS) nib[b] = in_sync[32'(nib_base_ff) + b];
      end
   end

   // Read mux; the pin register shows the real pin level, outputs too
   always_comb begin
      nxt_rdata = '0;
      nxt_rerr = 1'b0;
      case ({araddr[REG_AW-1:2], 2'b00})
         OFF_PLAIN_EN: nxt_rdata = 32'(plain_en_ff);
         OFF_PLAIN_DIR: nxt_rdata = 32'(plain_dir_ff);
         OFF_OUT_INIT: nxt_rdata = 32'(out_init_ff);
         OFF_OUT_DATA: nxt_rdata = 32'(out_ff);
         OFF_HARD_SEL: nxt_rdata = 32'(hard_sel_ff);
         OFF_HARD_DIR: nxt_rdata = 32'(hard_dir_ff);
         OFF_PIN_IN: nxt_rdata = 32'(in_sync);
         OFF_NIB_IN: nxt_rdata = 32'(nib);
         OFF_CTRL: nxt_rdata = 32'({nib_base_ff, 4'h0});
         OFF_RT_DIR: nxt_rdata = 32'(dir_rt_ff);
         OFF_PIRQ0: nxt_rdata = 32'(pirq_ff[0]);
         OFF_PIRQ1: nxt_rdata = 32'(pirq_ff[1]);
         OFF_TC_CFG: nxt_rdata = 32'(tc_cfg_ff);
         OFF_IRQ_STAT: nxt_rdata = 32'(stat_ff);
         OFF_IRQ_MASK: nxt_rdata = 32'(mask_ff);
         default: nxt_rerr = 1'b1;
      endcase
   end

   // Read channel: one read in flight, data held until taken
   assign arready = !rvalid_ff;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_ff <= 1'b0;
         rdata_ff <= '0;
         rresp_ff <= RESP_OKAY;
      end else if (arvalid && arready) begin
         rvalid_ff <= 1'b1;
         rdata_ff <= nxt_rdata;
         rresp_ff <= nxt_rerr ? RESP_SLVERR : RESP_OKAY;
      end else if (rready) begin
         rvalid_ff <= 1'b0;
      end
   end

   assign rvalid = rvalid_ff;
   assign rdata = rdata_ff;
   assign rresp = rresp_ff;

   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence app_rst_s;
      app_rst && !wr_to(OFF_OUT_DATA);
   endsequence

   sequence pin_steady_s;
      $stable(pin_i) [*4];
   endsequence

   hiz_unused_a: assert property ((pin_oe & ~(plain_own | hard_sel_ff)) == '0)
      else $error("unassigned pin is driven");
   hard_dir_a: assert property ((pin_oe & hard_sel_ff) == (hard_sel_ff & hard_dir_ff & exist))
      else $error("special function direction overridden");
   reapply_cfg_a: assert property (app_rst_s |=> dir_rt_ff == $past(plain_dir_ff))
      else $error("direction not reapplied on application reset");
   init_out_a: assert property (app_rst_s |=> (pin_o & plain_own) == (out_init_ff & plain_own))
      else $error("plain output not at initial value");
   sync_lat_a: assert property (pin_steady_s |=> in_sync == $past(pin_i))
      else $error("synchronised input not settled");
   rt_dir_a: assert property (wr_to(OFF_RT_DIR) && !app_rst && ws_ff == 4'hF
      |=> dir_rt_ff == $past(wd_ff[NUM_PINS-1:0]))
      else $error("run-time direction write lost");
   level_irq_a: assert property (pirq_ff[0][PIRQ_EN_BIT] && trig_code[0] == TRIG_HIGH
      && lvl_sel[0] |-> pin_irq[0] ##1 stat_ff[STAT_PIRQ0])
      else $error("level interrupt dropped while level held");
   edge_once_a: assert property (pin_irq[0] && trig_code[0] == TRIG_RISE
      && $stable(pirq_ff[0]) ##1 $stable(pirq_ff[0]) |-> !pin_irq[0])
      else $error("rising edge interrupt lasted two cycles");
   set_wins_a: assert property (ev[STAT_PIRQ1] && clr[STAT_PIRQ1] |=> stat_ff[STAT_PIRQ1])
      else $error("event lost against clear");
   tc_done_a: assert property (tc_mode == TC_DONE && tc_done_i ##1 mask_ff[STAT_TC] |-> irq)
      else $error("counter done did not raise interrupt");
   bresp_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
      else $error("write response dropped before bready");
endmodule

//--- common/gpp_pkg.sv
package gpp_pkg;
   // Pin count of the largest variant
   localparam int PIN_CNT = 12;
   // Bit width of the register byte address
   localparam int REG_AW = 8;
   // Register byte offsets
   localparam logic [7:0] OFF_PLAIN_EN = 8'h00;
   localparam logic [7:0] OFF_PLAIN_DIR = 8'h04;
   localparam logic [7:0] OFF_OUT_INIT = 8'h08;
   localparam logic [7:0] OFF_OUT_DATA = 8'h0C;
   localparam logic [7:0] OFF_HARD_SEL = 8'h10;
   localparam logic [7:0] OFF_HARD_DIR = 8'h14;
   localparam logic [7:0] OFF_PIN_IN = 8'h18;
   localparam logic [7:0] OFF_NIB_IN = 8'h1C;
   localparam logic [7:0] OFF_CTRL = 8'h20;
   localparam logic [7:0] OFF_RT_DIR = 8'h24;
   localparam logic [7:0] OFF_PIRQ0 = 8'h28;
   localparam logic [7:0] OFF_PIRQ1 = 8'h2C;
   localparam logic [7:0] OFF_TC_CFG = 8'h30;
   localparam logic [7:0] OFF_IRQ_STAT = 8'h34;
   localparam logic [7:0] OFF_IRQ_MASK = 8'h38;
   // Control register fields
   localparam int CTRL_APP_RST_BIT = 0;
   localparam int CTRL_NIB_LSB = 4;
   // Pin interrupt config fields: pin [3:0], trigger [6:4], enable [7]
   localparam int PIRQ_PIN_LSB = 0;
   localparam int PIRQ_TRIG_LSB = 4;
   localparam int PIRQ_EN_BIT = 7;
   // Trigger codes
   localparam logic [2:0] TRIG_HIGH = 3'h0;
   localparam logic [2:0] TRIG_LOW = 3'h1;
   localparam logic [2:0] TRIG_RISE = 3'h2;
   localparam logic [2:0] TRIG_FALL = 3'h3;
   localparam logic [2:0] TRIG_ANY = 3'h4;
   // Timer/counter config fields: pin [3:0], mode [5:4]
   localparam int TC_PIN_LSB = 0;
   localparam int TC_MODE_LSB = 4;
   localparam logic [1:0] TC_OFF = 2'h0;
   localparam logic [1:0] TC_CAP_RISE = 2'h1;
   localparam logic [1:0] TC_CAP_FALL = 2'h2;
   localparam logic [1:0] TC_DONE = 2'h3;
   // Status bit positions
   localparam int STAT_PIRQ0 = 0;
   localparam int STAT_PIRQ1 = 1;
   localparam int STAT_TC = 2;
   localparam int STAT_W = 3;
   // Reset values
   localparam logic [7:0] RST_PIRQ = 8'h00;
   localparam logic [5:0] RST_TC = 6'h00;
   localparam logic [3:0] RST_NIB = 4'h0;
   // AXI responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

//--- design/gpp_sync.sv
`timescale 1ns/1ps
module gpp_sync #(
   parameter int W = 12
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [W-1:0] raw,
   output logic [W-1:0] clean
);
   // Three stage chain; only stage two reads stage one
   logic [W-1:0] s1_ff;
   logic [W-1:0] s2_ff;
   logic [W-1:0] s3_ff;
   logic [W-1:0] clean_ff;
   logic [W-1:0] agree;

   // Shift chain
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s1_ff <= '0;
         s2_ff <= '0;
         s3_ff <= '0;
      end else begin
         s1_ff <= raw;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
      end
   end

   // A bit moves only when stages two and three agree, which filters a glitch
   assign agree = ~(s2_ff ^ s3_ff);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         clean_ff <= '0;
      end else begin
         clean_ff <= (agree & s2_ff) | (~agree & clean_ff);
      end
   end

   assign clean = clean_ff;
endmodule

//--- design/gpp_trig.sv
`timescale 1ns/1ps
module gpp_trig
   import gpp_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic lvl,
   input wire logic [2:0] trig,
   output logic hit
);
   // Previous sample and a primed flag
   logic prev_ff;
   logic prime_ff;

   // Priming blocks a false edge in the first cycle after reset
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         prev_ff <= 1'b0;
         prime_ff <= 1'b0;
      end else begin
         prev_ff <= lvl;
         prime_ff <= 1'b1;
      end
   end

   // Level trigger follows the input; edge triggers last one cycle
   always_comb begin
      case (trig)
         TRIG_HIGH: hit = lvl;
         TRIG_LOW: hit = !lvl;
         TRIG_RISE: hit = prime_ff && lvl && !prev_ff;
         TRIG_FALL: hit = prime_ff && !lvl && prev_ff;
         TRIG_ANY: hit = prime_ff && (lvl != prev_ff);
         default: hit = 1'b0;
      endcase
   end
endmodule

//--- tb/gpp_peer.sv
`timescale 1ns/1ps
// Peripherals on the pin side of the port
module gpp_peer
   import gpp_pkg::*;
(
   input wire logic [PIN_CNT-1:0] pin_o,
   input wire logic [PIN_CNT-1:0] pin_oe,
   input wire logic [PIN_CNT-1:0] ext_v,
   input wire logic [PIN_CNT-1:0] ext_en,
   output logic [PIN_CNT-1:0] pin_i
);
   // Port driver wins; a line nobody drives floats to its pull-up,
   // so a released pin never keeps showing the last driven level
   always_comb begin
      pin_i = (pin_oe & pin_o) | (~pin_oe & ext_en & ext_v) | (~pin_oe & ~ext_en);
   end
endmodule

//--- tb/testbench.sv
`timescale 1ns/1ps
module testbench
   import gpp_pkg::*;
;
   logic aclk = 1'h0;
   logic aresetn = 1'h0;
   logic [7:0] awaddr = '0;
   logic [7:0] araddr = '0;
   logic awvalid = 1'h0;
   logic wvalid = 1'h0;
   logic bready = 1'h0;
   logic arvalid = 1'h0;
   logic rready = 1'h0;
   logic tc_done_i = 1'h0;
   logic awready, wready, bvalid, arready, rvalid, irq;
   logic [31:0] wdata = '0;
   logic [31:0] rdata;
   // Full-word writes only
   logic [3:0] wstrb = 4'hF;
   logic [1:0] bresp, rresp, pin_irq;
   logic [11:0] pin_i, pin_o, pin_oe, spec_i;
   logic [11:0] spec_o = '0;
   // Bench drives pins 4 to 8, the rest rely on pull-ups
   logic [11:0] ext_v = '0;
   logic [11:0] ext_en = 12'h1F0;
   int fails = 0;
   int cmp_count = 0;
   // Expected status per trigger: after rise, clear, fall, clear
   logic [3:0] tt [5] = '{4'hE, 4'hB, 4'h8, 4'h2, 4'hA};
   // Timer configs: off, done pulse on pin 0, capture rise and capture fall on pin 8
   logic [7:0] tcc [4] = '{8'h00, 8'h30, 8'h18, 8'h28};

   always #25 aclk = ~aclk;

   gpp_port dut (
      .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
      .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
      .rready, .pin_i, .pin_o, .pin_oe, .spec_o, .spec_i, .tc_done_i, .pin_irq, .irq
   );

   gpp_peer peer (.pin_o, .pin_oe, .ext_v, .ext_en, .pin_i);

   // Compare one value and count it
   task automatic chk(input logic [33:0] got, input logic [33:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fails++;
         $display("Error at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask

   // Write one word; address and data are released as each is taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] er = RESP_OKAY);
      bit ah;
      bit dh;
      ah = 0;
      dh = 0;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      while (!(ah && dh)) begin
         @(posedge aclk);
         if (!ah && awready) begin
            ah = 1;
            awvalid <= 1'h0;
         end
         if (!dh && wready) begin
            dh = 1;
            wvalid <= 1'h0;
         end
      end
      do @(posedge aclk); while (!bvalid);
      bready <= 1'h0;
      chk(34'(bresp), 34'(er));
      // Spare edge so the next call never reassigns in this step
      @(posedge aclk);
   endtask

   // Read one word and compare response and data
   task automatic rc(input logic [7:0] a, input logic [31:0] e,
                     input logic [1:0] er = RESP_OKAY);
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      do @(posedge aclk); while (!arready);
      arvalid <= 1'h0;
      do @(posedge aclk); while (!rvalid);
      rready <= 1'h0;
      chk({rresp, rdata}, {er, e});
      @(posedge aclk);
   endtask

   // Verdict and end of run
   task automatic tally_and_finish;
      $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // Run takes a few hundred cycles; far beyond that is a hang
   initial begin
      repeat (20000) @(posedge aclk);
      fails++;
      tally_and_finish();
   end

   initial begin
      logic [1:0] e;
      repeat (2) @(posedge aclk);
      aresetn <= 1'h1;
      @(posedge aclk);
      // Nothing assigned yet: every driver off
      chk(34'(pin_oe), 34'h0);
      chk(34'(irq), 34'h0);
      // Pin 0 plain output with initial value 1, pins 4 to 8 plain inputs
      wr(OFF_PLAIN_EN, 32'h1F1);
      wr(OFF_OUT_INIT, 32'h1);
      wr(OFF_PLAIN_DIR, 32'h1);
      chk(34'(pin_oe), 34'h1);
      chk(34'(pin_o), 34'h0);
      // Application reset with nibble base 4 loads the initial value
      wr(OFF_CTRL, 32'h41);
      chk(34'(pin_o), 34'h1);
      ext_v <= 12'h0A0;
      repeat (6) @(posedge aclk);
      rc(OFF_PIN_IN, 32'hEAF);
      chk(34'(spec_i), 34'hEAF);
      rc(OFF_NIB_IN, 32'hA);
      // A fresh change is not visible until the synchroniser passes it
      ext_v <= 12'h050;
      rc(OFF_NIB_IN, 32'hA);
      repeat (4) @(posedge aclk);
      rc(OFF_NIB_IN, 32'h5);
      // Run-time direction under software control
      wr(OFF_RT_DIR, 32'h0);
      chk(34'(pin_oe), 34'h0);
      wr(OFF_RT_DIR, 32'h1);
      chk(34'(pin_oe), 34'h1);
      // Fixed-direction function takes pin 0 as input
      wr(OFF_HARD_DIR, 32'h0);
      wr(OFF_HARD_SEL, 32'h1);
      chk(34'(pin_oe), 34'h0);
      wr(OFF_PLAIN_DIR, 32'h1);
      chk(34'(pin_oe), 34'h0);
      // As output it drives its own value, not the plain one
      wr(OFF_HARD_DIR, 32'h1);
      chk(34'({pin_oe[0], pin_o[0]}), 34'h2);
      wr(OFF_HARD_SEL, 32'h0);
      // Both detectors on plain input pin 8, second one on any edge
      wr(OFF_IRQ_MASK, 32'h7);
      wr(OFF_PIRQ1, 32'hC8);
      for (int t = 0; t < 5; t++) begin
         wr(OFF_PIRQ0, 32'h88 | 32'(t << 4));
         wr(OFF_IRQ_STAT, 32'h7);
         for (int s = 0; s < 4; s++) begin
            if (s[0] == 1'b0) begin
               ext_v[8] <= (s == 0);
               repeat (6) @(posedge aclk);
            end else begin
               wr(OFF_IRQ_STAT, 32'h7);
            end
            e = {s[0] == 1'b0, tt[t][3 - s]};
            rc(OFF_IRQ_STAT, 32'(e));
            chk(34'(irq), 34'(|e));
            if (s[0]) begin
               chk(34'(pin_irq[0]), 34'(tt[t][3 - s]));
            end
         end
      end
      // Timer pulse counts only once its mode selects it
      wr(OFF_PIRQ0, 32'h0);
      wr(OFF_PIRQ1, 32'h0);
      // Each step offers a done pulse and a pin 8 edge; only the selected source counts
      for (int m = 0; m < 4; m++) begin
         wr(OFF_TC_CFG, 32'(tcc[m]));
         wr(OFF_IRQ_STAT, 32'h7);
         tc_done_i <= 1'h1;
         ext_v[8] <= (m[0] == 1'b0);
         @(posedge aclk);
         tc_done_i <= 1'h0;
         repeat (6) @(posedge aclk);
         rc(OFF_IRQ_STAT, m ? 32'h4 : 32'h0);
      end
      chk(34'(irq), 34'h1);
      wr(OFF_IRQ_MASK, 32'h3);
      chk(34'(irq), 34'h0);
      wr(OFF_IRQ_STAT, 32'h4);
      rc(OFF_IRQ_STAT, 32'h0);
      // Unmapped offset is refused both ways
      wr(8'h3C, 32'h1, RESP_SLVERR);
      rc(8'h3C, 32'h0, RESP_SLVERR);
      tally_and_finish();
   end
endmodule
